// File: hw/lgl_host.sv
// Host controller that writes gain settings into the latch through its pins.
`timescale 1ns/1ps
// What this block and the latch do
// RQ1: Each setting is presented on the data pins and latched by a rising write strobe.
// RQ2: Chip select is held low around every strobe so the device accepts it.
// RQ3: Register select is driven to the intended word before and through each strobe.
// RQ4: On the byte-wide variant a full setting is sent as two eight-bit writes.
// RQ5: The power-down bit travels in the second write of the byte-wide variant.
// RQ6: The nine-bit variant receives the whole setting in one write.
// RQ7: Pin two carries power-down or fine bit two by selected word, fine bit two when wide.
// RQ8: Pin one carries fine bit one or fine bit zero by selected word, fine bit one when wide.
// RQ9: Pin zero is used only on the wide variant and carries fine bit zero.
// RQ10: Attenuate select one with zero steps gives unity gain in the device.
// RQ11: The setting spans minus to plus twenty-four decibels in tenth steps.
// RQ12: Word zero loads attenuate, coarse and fine three to one; word one loads power-down and fine zero.
// RQ13: Power-down one stops the device analog part while its stored words are kept.
// RQ14: Coarse steps of one and a half and fine steps of a tenth decibel add together.
// RQ15: Attenuate select turns the combined step value into attenuation.
// RQ16: A write to one word leaves the other word of the device unchanged.
module lgl_host
    import lgl_pkg::*;
#(
    parameter lgl_variant_t VARIANT = LGL_BYTE
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reqValid,
    input lgl_setting_t reqSetting,
    input wire logic reqPowerDown,
    input wire logic reqSecondOnly,
    output logic reqReady,
    output logic doneStrobe,
    output logic [8:0] settingPins,
    output logic registerSelect,
    output logic csN,
    output logic wrN,
    output logic powerDownShadow
);
    typedef enum logic [2:0] {S_IDLE, S_SEL, S_SETUP, S_STROBE, S_HOLD} lgl_state_t;

    logic rstMeta_reg;
    logic rstN;
    lgl_state_t state_reg;
    lgl_setting_t setting_reg;
    logic pdn_reg;
    logic second_reg;
    logic timerLoad;
    logic [7:0] timerCount;
    logic timerDone;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_reg <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstN <= rstMeta_reg;
        end
    end

    // Build the pin word for a given register select.
    function automatic lgl_word_t pin_word(input lgl_setting_t s, input logic power_down_bit,
                                           input logic sel);
        lgl_word_t w;
        w.settingPins = PINS_RESET;
        w.registerSelect = sel;
        if (VARIANT == LGL_WIDE) begin
            w.settingPins = s; // RQ6 RQ9
            w.registerSelect = 1'b0;
        end else if (!sel) begin
            w.settingPins[ATTEN_POS:1] = {s.attenuateSelect, s.coarseStep, s.fineStep[3:1]}; // RQ12
        end else begin
            w.settingPins[PDN_PIN] = power_down_bit; // RQ5 RQ7 RQ13
            w.settingPins[FINE0_PIN] = s.fineStep[0]; // RQ8 RQ12
        end
        return w;
    endfunction : pin_word

    lgl_strobe_timer #(.CW(8)) uTimer (
        .mclk(mclk),
        .rstN(rstN),
        .load(timerLoad),
        .count(timerCount),
        .done(timerDone)
    );

    always_comb begin
        timerLoad = 1'b0;
        timerCount = 8'h00;
        unique case (state_reg)
            S_IDLE: begin
                timerLoad = reqValid;
                timerCount = 8'(SELECT_CYCLES);
            end
            S_SEL: begin
                timerLoad = timerDone;
                timerCount = 8'(SETUP_CYCLES);
            end
            S_SETUP: begin
                timerLoad = timerDone;
                timerCount = 8'(WIDTH_CYCLES);
            end
            S_STROBE: begin
                timerLoad = timerDone;
                timerCount = 8'(HOLD_CYCLES);
            end
            S_HOLD: begin
                timerLoad = timerDone && VARIANT == LGL_BYTE && !second_reg;
                timerCount = 8'(SELECT_CYCLES);
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            state_reg <= S_IDLE;
        end else begin
            unique case (state_reg)
                S_IDLE: if (reqValid) state_reg <= S_SEL;
                S_SEL: if (timerDone) state_reg <= S_SETUP;
                S_SETUP: if (timerDone) state_reg <= S_STROBE;
                S_STROBE: if (timerDone) state_reg <= S_HOLD;
                S_HOLD: if (timerDone) state_reg <= timerLoad ? S_SEL : S_IDLE; // RQ4
            endcase
        end
    end

    // Request capture and word sequencing.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            setting_reg <= '0;
            pdn_reg <= 1'b0;
            second_reg <= 1'b0;
        end else if (state_reg == S_IDLE && reqValid) begin
            setting_reg <= reqSetting;
            pdn_reg <= reqPowerDown;
            second_reg <= reqSecondOnly && VARIANT == LGL_BYTE; // RQ16
        end else if (state_reg == S_HOLD && timerLoad) begin
            second_reg <= 1'b1; // RQ4
        end
    end

    // Pins change only outside the strobe so setup and hold both stand.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            settingPins <= PINS_RESET;
            registerSelect <= 1'b0;
            csN <= 1'b1;
            wrN <= 1'b1;
            reqReady <= 1'b0;
            doneStrobe <= 1'b0;
            powerDownShadow <= 1'b0;
        end else begin
            reqReady <= (state_reg == S_IDLE) && !reqValid;
            doneStrobe <= (state_reg == S_HOLD) && timerDone && !timerLoad;
            if (state_reg == S_SEL) begin
                {settingPins, registerSelect} <= pin_word(setting_reg, pdn_reg, second_reg); // RQ3
                csN <= 1'b0; // RQ2
            end else if (state_reg == S_IDLE) begin
                csN <= 1'b1;
            end
            // The strobe falls on entry to the strobe phase so it stays low the full count.
            wrN <= !((state_reg == S_SETUP && timerDone) ||
                     (state_reg == S_STROBE && !timerDone)); // RQ1
            if (state_reg == S_HOLD && timerDone && VARIANT == LGL_BYTE && second_reg) begin
                powerDownShadow <= pdn_reg; // RQ13
            end
        end
    end
endmodule : lgl_host

// File: shared/lgl_pkg.sv
// Package of constants and types for the gain-setting latch host controller.
package lgl_pkg;

    // Pin timing in nanoseconds.
    localparam int DATA_SETUP_NS = 50;
    localparam int DATA_HOLD_NS = 50;
    localparam int STROBE_WIDTH_NS = 50;
    localparam int SELECT_SETUP_NS = 0;
    localparam int CLK_PERIOD_NS = 5;

    // Least times round up and never fall below one cycle.
    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cycles

    localparam int SETUP_CYCLES = ns_to_cycles(DATA_SETUP_NS);
    localparam int HOLD_CYCLES = ns_to_cycles(DATA_HOLD_NS);
    localparam int WIDTH_CYCLES = ns_to_cycles(STROBE_WIDTH_NS);
    localparam int SELECT_CYCLES = ns_to_cycles(SELECT_SETUP_NS);

    // Setting word field positions.
    localparam int FINE_LSB = 0;
    localparam int COARSE_LSB = 4;
    localparam int ATTEN_POS = 8;
    localparam int PINS_WIDTH = 9;

    // Second-word pin positions on the byte-wide variant.
    localparam int PDN_PIN = 2;
    localparam int FINE0_PIN = 1;

    // Reset values of the pins; while idle they keep the last word driven.
    localparam logic [8:0] PINS_RESET = 9'h000;
    localparam logic [9:0] DIV_RESET = 10'h000;

    typedef struct packed {
        logic attenuateSelect;
        logic [3:0] coarseStep;
        logic [3:0] fineStep;
    } lgl_setting_t;

    typedef struct packed {
        logic [8:0] settingPins;
        logic registerSelect;
    } lgl_word_t;

    typedef enum logic {LGL_WIDE, LGL_BYTE} lgl_variant_t;
endpackage : lgl_pkg

// File: hw/lgl_strobe_timer.sv
// Counter that paces each phase of one strobe cycle.
`timescale 1ns/1ps
module lgl_strobe_timer
    import lgl_pkg::*;
#(
    parameter int CW = 8
) (
    input wire logic mclk,
    input wire logic rstN,
    input wire logic load,
    input wire logic [CW-1:0] count,
    output logic done
);
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= count;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // Done stands in the last cycle of a loaded count, so a load of N gives N cycles.
    // It must not look at load, since the sequencer derives load from done.
    assign done = (cnt_reg == {{(CW-1){1'b0}}, 1'b1});
endmodule : lgl_strobe_timer

// File: verification/lgl_dev_model.sv
// Behavioural model of the gain latch at the far end of the pins.
`timescale 1ns/1ps
module lgl_dev_model (
    input wire logic [8:0] settingPins,
    input wire logic registerSelect,
    input wire logic csN,
    input wire logic wrN,
    output logic [7:0] wordZero,
    output logic [1:0] wordOne
);
    // The latch has no reset, so a word stays unknown until it is first written.
    always_ff @(posedge wrN) begin
        if (!csN && !registerSelect) wordZero <= settingPins[8:1];
        if (!csN && registerSelect) wordOne <= settingPins[2:1];
    end
endmodule : lgl_dev_model

// File: verification/lgl_host_sva.sv
// Pin-side assertions for the gain latch host controller.
`timescale 1ns/1ps
module lgl_host_sva (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reqReady,
    input wire logic doneStrobe,
    input wire logic [8:0] settingPins,
    input wire logic registerSelect,
    input wire logic csN,
    input wire logic wrN
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_cs_around_wr: assert property (!wrN |-> !csN) else $error("strobe unselected");
    a_wr_width: assert property ($fell(wrN) |-> !wrN [*8]) else $error("strobe short");
    a_data_setup: assert property ($fell(wrN) |->
        $past({registerSelect, settingPins}, 8) == {registerSelect, settingPins}) else $error("setup");
    a_data_hold: assert property ($rose(wrN) |=>
        $stable({registerSelect, settingPins}) [*8]) else $error("hold");
    a_pin_zero: assert property (!csN |-> !settingPins[0]) else $error("pin zero used");
    a_two_writes: assert property ($rose(wrN) && !registerSelect |->
        ##[1:40] ($fell(wrN) && registerSelect)) else $error("no second write");
    a_done_after_last: assert property ($rose(wrN) && registerSelect |->
        ##[1:20] doneStrobe) else $error("no done");
    a_busy_not_ready: assert property (!csN |-> !reqReady) else $error("ready busy");
    c_word_zero: cover property ($rose(wrN) && !registerSelect);
    c_word_one: cover property ($rose(wrN) && registerSelect);
    c_done: cover property (doneStrobe);
endmodule : lgl_host_sva
bind lgl_host lgl_host_sva i_lgl_host_sva (.*);

// File: verification/lgl_host_tb_top.sv
// Bench for the gain latch host controller, byte-wide variant.
`timescale 1ns/1ps
module lgl_host_tb_top
    import lgl_pkg::*;
;
    typedef struct packed {lgl_setting_t s; logic p;} lgl_row_t;
    lgl_row_t rows [4] = '{'{9'h100, 1'b0}, '{9'h1ff, 1'b1}, '{9'h0ff, 1'b0},
        '{9'h011, 1'b0}};
    logic mclk = 1'b0, reset_n = 1'b0, reqValid = 1'b0, reqPowerDown = 1'b0, reqSecondOnly = 1'b0;
    lgl_setting_t reqSetting = '0;
    logic reqReady, doneStrobe, registerSelect, csN, wrN, powerDownShadow;
    logic [8:0] settingPins;
    logic [7:0] wordZero;
    logic [1:0] wordOne;
    int errors = 0, tests_run = 0;
    initial forever #2.5 mclk = ~mclk;
    lgl_host #(.VARIANT(LGL_BYTE)) i_lgl_host (.*);
    lgl_dev_model i_lgl_dev_model (.*);
    task automatic tally_and_finish();
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (!ok) begin
            errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task automatic wt(input logic d);
        int n;
        for (n = 0; n < 300 && (d ? doneStrobe : reqReady) !== 1'b1; n++) @(posedge mclk);
        chk(n < 300, "no handshake");
    endtask : wt
    task automatic send(input lgl_setting_t s, input logic p, input logic so);
        wt(1'b0);
        reqSetting <= s;
        reqPowerDown <= p;
        reqSecondOnly <= so;
        reqValid <= 1'b1;
        @(posedge mclk);
        reqValid <= 1'b0;
        wt(1'b1);
    endtask : send
    initial begin
        repeat (2) @(posedge mclk);
        chk(csN === 1'b1 && wrN === 1'b1 && reqReady === 1'b0, "reset pins");
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            send(rows[i].s, rows[i].p, 1'b0);
            chk(wordZero === rows[i].s[8:1], "word zero");
            chk(wordOne === {rows[i].p, rows[i].s[0]}, "word one");
            chk(powerDownShadow === rows[i].p, "shadow");
        end
        // Only word one goes out, so word zero must keep the last row.
        send(9'h000, 1'b1, 1'b1);
        chk(wordZero === rows[3].s[8:1] && wordOne === 2'b10, "lone word");
        chk(powerDownShadow === 1'b1, "lone shadow");
        tally_and_finish();
    end
    initial begin
        #20000;
        chk(1'b0, "timeout");
        tally_and_finish();
    end
endmodule : lgl_host_tb_top
